// ---- tcs_cfg.svh ----
// Constants for the timer clock select and prescaler block.
// Assumes a single system clock domain; included by bare name.
`ifndef TCS_CFG_SVH
`define TCS_CFG_SVH

// Register addresses on the special function register port
`define TCS_CLK_CTRL_ADDR      8'h8e
`define TCS_CLK_CTRL_EXT_ADDR  8'hf4

// Reset values
`define TCS_CLK_CTRL_RST       8'h00
`define TCS_CLK_CTRL_EXT_RST   4'h0

// Field positions, first control register
`define TCS_PRESCALE_LSB       0
`define TCS_PRESCALE_MSB       1
`define TCS_T0_SEL_BIT         2
`define TCS_T1_SEL_BIT         3
`define TCS_T2_LOW_BIT         4
`define TCS_T2_HIGH_BIT        5
`define TCS_T3_LOW_BIT         6
`define TCS_T3_HIGH_BIT        7

// Field positions, second control register
`define TCS_T4_LOW_BIT         0
`define TCS_T4_HIGH_BIT        1
`define TCS_T5_LOW_BIT         2
`define TCS_T5_HIGH_BIT        3
`define TCS_EXT_USED_W         4

// Divide ratios, in system clock cycles or external clock edges
`define TCS_DIV_FAST           4
`define TCS_DIV_MID            12
`define TCS_DIV_SLOW           48
`define TCS_DIV_EXT            8

`endif

// ---- tcs_pkg.sv ----
// Types shared by the timer clock select block.
// Assumes nothing beyond a SystemVerilog compiler.
package tcs_pkg;

  // Prescale field encodings in their documented order
  typedef enum logic [1:0] {
    TCS_PS_MID,
    TCS_PS_FAST,
    TCS_PS_SLOW,
    TCS_PS_EXT
  } tcs_prescale_t;

  // Timer 0/1 operating modes in their documented order
  typedef enum logic [1:0] {
    TCS_MODE_13,
    TCS_MODE_16,
    TCS_MODE_RELOAD8,
    TCS_MODE_SPLIT8
  } tcs_t01_mode_t;

endpackage : tcs_pkg

// ---- tcs_sync.sv ----
// Two-stage synchronizer with edge pulses on the system clock.
// Assumes the input is asynchronous and slower than a quarter of clk.
module tcs_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Asynchronous level
  input  wire logic async_in,
  // Synchronized level and one-cycle edge pulses
  output logic      level,
  output logic      fall,
  output logic      rise
);

  logic meta_r;
  logic sync_r;
  logic prev_r;

  // First flop feeds only the second one
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign level = sync_r;
  assign fall  = prev_r & ~sync_r;
  assign rise  = ~prev_r & sync_r;

endmodule // tcs_sync

// ---- tcs_top.sv ----
// Count clock selection and prescaler for six counter/timers.
// Assumes the timer logic consumes one-cycle tick enables on clk and
// drives its mode bits from clk-domain flops.
//
// Functional notes
// - Six 16-bit counter/timers are served: Timers 0, 1 and four reload.
// - Timers 0/1 have 13, 16, reload-8 modes; split 8 is Timer 0 only.
// - Timers 2-5 run as one 16-bit or two 8-bit reload timers.
// - Timer 0/1 clock comes from five sources via select bit and prescale.
// - Timers 2-5 use system clock, system clock /12, or external /8.
// - In counter mode, each falling pin edge gives one count.
// - Events up to a quarter of the system clock rate are counted.
// - Prescale 00 /12, 01 /4, 10 /48, 11 external /8 synchronized.
// - Bit 3 selects Timer 1 prescaled (0) or system clock; ignored counting.
// - Bit 2 selects Timer 0 prescaled (0) or system clock; ignored counting.
// - Bits 4/5 pick Timer 2 low/high clock; high acts only when split.
// - Bits 6/7 pick Timer 3 low/high clock; high acts only when split.
// - Second register bits 0/1 pick Timer 4 low/high clocks.
// - Second register bits 2/3 pick Timer 5 low/high clocks.
// - Upper four bits of second register read zero, writes ignored.
// - Counter mode bit picks pin edges (1) or selected clock (0); Timer 1 keeps its selected clock while Timer 0 is split.
`include "tcs_cfg.svh"

module tcs_top (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_b,
  // Special function register port
  input  wire logic [7:0]             sfr_addr,
  input  wire logic                   sfr_wr,
  input  wire logic                   sfr_rd,
  input  wire logic [7:0]             sfr_wdata,
  output logic      [7:0]             sfr_rdata,
  // Pins
  input  wire logic                   event_input_zero,
  input  wire logic                   event_input_one,
  input  wire logic                   ext_osc_clk,
  // Timer 0/1 configuration
  input  wire tcs_pkg::tcs_t01_mode_t timer_zero_mode,
  input  wire tcs_pkg::tcs_t01_mode_t timer_one_mode,
  input  wire logic                   timer_zero_counter_mode,
  input  wire logic                   timer_one_counter_mode,
  // Timer 2-5 configuration
  input  wire logic                   timer_two_split,
  input  wire logic                   timer_three_split,
  input  wire logic                   timer_four_split,
  input  wire logic                   timer_five_split,
  input  wire logic                   timer_two_alt_clock_bit,
  input  wire logic                   timer_three_alt_clock_bit,
  input  wire logic                   timer_four_alt_clock_bit,
  input  wire logic                   timer_five_alt_clock_bit,
  // Count enables
  output logic                        timer_zero_tick,
  output logic                        timer_zero_high_tick,
  output logic                        timer_one_tick,
  output logic                        timer_two_low_tick,
  output logic                        timer_two_high_tick,
  output logic                        timer_three_low_tick,
  output logic                        timer_three_high_tick,
  output logic                        timer_four_low_tick,
  output logic                        timer_four_high_tick,
  output logic                        timer_five_low_tick,
  output logic                        timer_five_high_tick
);

  import tcs_pkg::*;

  localparam int DIV_FAST = `TCS_DIV_FAST;
  localparam int DIV_MID  = `TCS_DIV_MID;
  localparam int DIV_SLOW = `TCS_DIV_SLOW;
  localparam int DIV_EXT  = `TCS_DIV_EXT;
  localparam int SLOW_OF_MID = DIV_SLOW / DIV_MID;
  localparam int FAST_W = $clog2(DIV_FAST);
  localparam int MID_W  = $clog2(DIV_MID);
  localparam int SLOW_W = $clog2(SLOW_OF_MID);
  localparam int EXT_W  = $clog2(DIV_EXT);

  // Registers
  logic [7:0]                  clk_ctrl_r;
  logic [`TCS_EXT_USED_W-1:0]  clk_ctrl_ext_r;

  // Prescaler state
  logic [FAST_W-1:0] fast_cnt_r;
  logic [MID_W-1:0]  mid_cnt_r;
  logic [SLOW_W-1:0] slow_cnt_r;
  logic [EXT_W-1:0]  ext_cnt_r;
  logic              fast_tick;
  logic              mid_tick;
  logic              slow_tick;
  logic              ext_tick;
  logic              presc_tick;
  tcs_prescale_t     prescale_select;

  // Synchronized pins
  logic ev0_fall;
  logic ev1_fall;
  logic ext_rise;

  // Next tick values
  logic t0_nxt;
  logic t0h_nxt;
  logic t1_nxt;
  logic t2l_nxt;
  logic t2h_nxt;
  logic t3l_nxt;
  logic t3h_nxt;
  logic t4l_nxt;
  logic t4h_nxt;
  logic t5l_nxt;
  logic t5h_nxt;

  // A select bit of 1 means the undivided system clock
  function automatic logic pick(input logic use_sys, input logic other);
    pick = use_sys | other;
  endfunction

  // Clock named by a timer's alternate clock bit
  function automatic logic alt_src(input logic alt, input logic mid,
                                   input logic ext);
    alt_src = alt ? ext : mid;
  endfunction

  // Register writes
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      clk_ctrl_r     <= `TCS_CLK_CTRL_RST;
      clk_ctrl_ext_r <= `TCS_CLK_CTRL_EXT_RST;
    end else if (sfr_wr) begin
      if (sfr_addr == `TCS_CLK_CTRL_ADDR) begin
        clk_ctrl_r <= sfr_wdata;
      end
      if (sfr_addr == `TCS_CLK_CTRL_EXT_ADDR) begin
        clk_ctrl_ext_r <= sfr_wdata[`TCS_EXT_USED_W-1:0];
      end
    end
  end

  // Register reads, answered one cycle later; unmapped reads give zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      case (sfr_addr)
        `TCS_CLK_CTRL_ADDR:     sfr_rdata <= clk_ctrl_r;
        `TCS_CLK_CTRL_EXT_ADDR: sfr_rdata <= {4'h0, clk_ctrl_ext_r};
        default:                sfr_rdata <= 8'h00;
      endcase
    end
  end

  // Pin synchronizers; raw pins never clock anything
  tcs_sync u_sync_ev0 (
    .clk      (clk),
    .rst_b    (rst_b),
    .async_in (event_input_zero),
    .level    (),
    .fall     (ev0_fall),
    .rise     ()
  );

  tcs_sync u_sync_ev1 (
    .clk      (clk),
    .rst_b    (rst_b),
    .async_in (event_input_one),
    .level    (),
    .fall     (ev1_fall),
    .rise     ()
  );

  tcs_sync u_sync_ext (
    .clk      (clk),
    .rst_b    (rst_b),
    .async_in (ext_osc_clk),
    .level    (),
    .fall     (),
    .rise     (ext_rise)
  );

  // Free-running dividers as enable pulses
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fast_cnt_r <= '0;
    end else if (fast_tick) begin
      fast_cnt_r <= '0;
    end else begin
      fast_cnt_r <= fast_cnt_r + FAST_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mid_cnt_r <= '0;
    end else if (mid_tick) begin
      mid_cnt_r <= '0;
    end else begin
      mid_cnt_r <= mid_cnt_r + MID_W'(1);
    end
  end

  // Slow divider counts mid pulses so it stays phase-locked to them
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      slow_cnt_r <= '0;
    end else if (mid_tick) begin
      slow_cnt_r <= slow_cnt_r + SLOW_W'(1);
    end
  end

  // External clock divider counts synchronized rising edges
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_cnt_r <= '0;
    end else if (ext_rise) begin
      ext_cnt_r <= ext_cnt_r + EXT_W'(1);
    end
  end

  assign fast_tick = (fast_cnt_r == FAST_W'(DIV_FAST - 1));
  assign mid_tick  = (mid_cnt_r == MID_W'(DIV_MID - 1));
  assign slow_tick = mid_tick & (slow_cnt_r == SLOW_W'(SLOW_OF_MID - 1));
  assign ext_tick  = ext_rise & (ext_cnt_r == EXT_W'(DIV_EXT - 1));

  // Prescaled clock for Timers 0 and 1
  assign prescale_select = tcs_prescale_t'(
    clk_ctrl_r[`TCS_PRESCALE_MSB:`TCS_PRESCALE_LSB]);

  always_comb begin
    case (prescale_select)
      TCS_PS_MID:  presc_tick = mid_tick;
      TCS_PS_FAST: presc_tick = fast_tick;
      TCS_PS_SLOW: presc_tick = slow_tick;
      TCS_PS_EXT:  presc_tick = ext_tick;
      default:     presc_tick = 1'b0;
    endcase
  end

  // Timer 0 and Timer 1 selection
  always_comb begin
    // Counter mode overrides the select bit
    if (timer_zero_counter_mode) begin
      t0_nxt = ev0_fall;
    end else begin
      t0_nxt = pick(clk_ctrl_r[`TCS_T0_SEL_BIT], presc_tick);
    end
    // Split high byte is a timer only, never pin driven
    if (timer_zero_mode == TCS_MODE_SPLIT8) begin
      t0h_nxt = pick(clk_ctrl_r[`TCS_T0_SEL_BIT], presc_tick);
    end else begin
      t0h_nxt = 1'b0;
    end
    // Timer 1 has no split mode; that setting stops it
    if (timer_one_mode == TCS_MODE_SPLIT8) begin
      t1_nxt = 1'b0;
    end else if (timer_one_counter_mode &&
                 timer_zero_mode != TCS_MODE_SPLIT8) begin
      t1_nxt = ev1_fall;
    end else begin
      t1_nxt = pick(clk_ctrl_r[`TCS_T1_SEL_BIT], presc_tick);
    end
  end

  // Timers 2 to 5: low byte always, high byte own select only when split
  always_comb begin
    t2l_nxt = pick(clk_ctrl_r[`TCS_T2_LOW_BIT],
      alt_src(timer_two_alt_clock_bit, mid_tick, ext_tick));
    t2h_nxt = timer_two_split ?
      pick(clk_ctrl_r[`TCS_T2_HIGH_BIT],
        alt_src(timer_two_alt_clock_bit, mid_tick, ext_tick)) :
      t2l_nxt;
    t3l_nxt = pick(clk_ctrl_r[`TCS_T3_LOW_BIT],
      alt_src(timer_three_alt_clock_bit, mid_tick, ext_tick));
    t3h_nxt = timer_three_split ?
      pick(clk_ctrl_r[`TCS_T3_HIGH_BIT],
        alt_src(timer_three_alt_clock_bit, mid_tick, ext_tick)) :
      t3l_nxt;
    t4l_nxt = pick(clk_ctrl_ext_r[`TCS_T4_LOW_BIT],
      alt_src(timer_four_alt_clock_bit, mid_tick, ext_tick));
    t4h_nxt = timer_four_split ?
      pick(clk_ctrl_ext_r[`TCS_T4_HIGH_BIT],
        alt_src(timer_four_alt_clock_bit, mid_tick, ext_tick)) :
      t4l_nxt;
    t5l_nxt = pick(clk_ctrl_ext_r[`TCS_T5_LOW_BIT],
      alt_src(timer_five_alt_clock_bit, mid_tick, ext_tick));
    t5h_nxt = timer_five_split ?
      pick(clk_ctrl_ext_r[`TCS_T5_HIGH_BIT],
        alt_src(timer_five_alt_clock_bit, mid_tick, ext_tick)) :
      t5l_nxt;
  end

  // Registered ticks: one cycle of latency buys glitch-free enables
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_zero_tick       <= 1'b0;
      timer_zero_high_tick  <= 1'b0;
      timer_one_tick        <= 1'b0;
      timer_two_low_tick    <= 1'b0;
      timer_two_high_tick   <= 1'b0;
      timer_three_low_tick  <= 1'b0;
      timer_three_high_tick <= 1'b0;
      timer_four_low_tick   <= 1'b0;
      timer_four_high_tick  <= 1'b0;
      timer_five_low_tick   <= 1'b0;
      timer_five_high_tick  <= 1'b0;
    end else begin
      timer_zero_tick       <= t0_nxt;
      timer_zero_high_tick  <= t0h_nxt;
      timer_one_tick        <= t1_nxt;
      timer_two_low_tick    <= t2l_nxt;
      timer_two_high_tick   <= t2h_nxt;
      timer_three_low_tick  <= t3l_nxt;
      timer_three_high_tick <= t3h_nxt;
      timer_four_low_tick   <= t4l_nxt;
      timer_four_high_tick  <= t4h_nxt;
      timer_five_low_tick   <= t5l_nxt;
      timer_five_high_tick  <= t5h_nxt;
    end
  end

endmodule // tcs_top

// ---- tcs_chk_asserts.sv ----
// Checker for the timer clock select block, bound to its top module.
// Assumes the register and tick timing of the designer's hand-over.
module tcs_chk (
  // Clock and reset
  input logic                   clk,
  input logic                   rst_b,
  // Register port
  input logic [7:0]             sfr_addr,
  input logic                   sfr_wr,
  input logic                   sfr_rd,
  input logic [7:0]             sfr_wdata,
  input logic [7:0]             sfr_rdata,
  // Pins and timer configuration
  input logic                   event_input_zero,
  input tcs_pkg::tcs_t01_mode_t timer_zero_mode,
  input tcs_pkg::tcs_t01_mode_t timer_one_mode,
  input logic                   timer_zero_counter_mode,
  input logic                   timer_five_split,
  // Count enables
  input logic                   timer_zero_tick,
  input logic                   timer_zero_high_tick,
  input logic                   timer_one_tick,
  input logic                   timer_two_low_tick,
  input logic                   timer_five_low_tick,
  input logic                   timer_five_high_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  import tcs_pkg::*;
  logic [7:0] ck_r;
  logic [7:0] fast_h_r;
  logic [3:0] gap_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Shadow of the first register, updated on the same edge as the design
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ck_r <= 8'h00;
    end else if (sfr_wr && sfr_addr == 8'h8e) begin
      ck_r <= sfr_wdata;
    end
  end
  // Eight cycles of steady divide-by-4 choice before the gap is trusted
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fast_h_r <= 8'h00;
      gap_r <= 4'h0;
    end else begin
      fast_h_r <= {fast_h_r[6:0],
                   ck_r[2:0] == 3'h1 && !timer_zero_counter_mode};
      gap_r <= timer_zero_tick ? 4'h1 : gap_r + {3'h0, gap_r != 4'hf};
    end
  end
  AST_EXT_UPPER: assert property (
    sfr_rd && sfr_addr == 8'hf4 |=> sfr_rdata[7:4] == 4'h0)
    else $error("upper bits of second register not zero");
  AST_TIMER_CLOCK_CONTROL_RD: assert property (
    sfr_rd && sfr_addr == 8'h8e |=> sfr_rdata == $past(ck_r))
    else $error("first register read back wrong");
  AST_T1_SPLIT_OFF: assert property (
    timer_one_mode == TCS_MODE_SPLIT8 |=> !timer_one_tick)
    else $error("timer 1 ticks in split mode");
  AST_T0_HIGH_OFF: assert property (
    timer_zero_mode != TCS_MODE_SPLIT8 |=> !timer_zero_high_tick)
    else $error("timer 0 high tick outside split mode");
  AST_T0_SYSTEM_CLOCK: assert property (
    ck_r[2] && !timer_zero_counter_mode |=> timer_zero_tick)
    else $error("timer 0 not on system clock");
  AST_T2_LOW_SYS: assert property (
    ck_r[4] |=> timer_two_low_tick)
    else $error("timer 2 low not on system clock");
  AST_T5_PAIR: assert property (
    !timer_five_split |=> timer_five_high_tick == timer_five_low_tick)
    else $error("timer 5 halves differ outside split mode");
  AST_FAST_GAP: assert property (
    &fast_h_r && timer_zero_tick |-> gap_r == 4'h4)
    else $error("prescale divide by 4 period wrong");
  AST_PIN_FALL: assert property (
    timer_zero_counter_mode && $fell(event_input_zero)
      |-> ##[2:5] timer_zero_tick)
    else $error("pin fall gave no count");
  cover property (&fast_h_r && timer_zero_tick);
  cover property (timer_zero_counter_mode && timer_zero_tick);
  cover property (sfr_rd && sfr_addr == 8'hf4);
  cover property (timer_zero_mode == TCS_MODE_SPLIT8 && timer_zero_high_tick);
endmodule // tcs_chk

bind tcs_top tcs_chk u_chk (.*);

// ---- tcs_far_end.sv ----
// Far-end model: event pins and free-running external oscillator.
// Assumes the bench starts each burst with a one-cycle go pulse.
module tcs_far_end (
  // Clock and reset
  input  logic       clk,
  input  logic       rst_b,
  // Burst control
  input  logic       go,
  input  logic [3:0] half,
  input  logic [7:0] count,
  // Pins
  output logic       event_input_zero,
  output logic       event_input_one,
  output logic       ext_osc_clk,
  output logic       done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] left_r;
  logic [3:0] ph_r;
  logic [2:0] osc_r;
  // Pins idle high as if pulled up
  assign event_input_one = event_input_zero;
  assign done = left_r == 9'h000;
  // Each level stands half cycles; half of 2 is the clk/4 limit
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      left_r <= 9'h000;
      ph_r <= 4'h0;
      event_input_zero <= 1'b1;
    end else if (go) begin
      left_r <= {count, 1'b0} - 9'h001;
      ph_r <= 4'h1;
      event_input_zero <= 1'b0;
    end else if (!done && ph_r == half) begin
      left_r <= left_r - 9'h001;
      ph_r <= 4'h1;
      event_input_zero <= ~event_input_zero;
    end else begin
      ph_r <= ph_r + 4'h1;
    end
  end
  // Period of six clocks, so a divide by 8 ticks once per 48
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      osc_r <= 3'h0;
      ext_osc_clk <= 1'b0;
    end else if (osc_r == 3'h2) begin
      osc_r <= 3'h0;
      ext_osc_clk <= ~ext_osc_clk;
    end else begin
      osc_r <= osc_r + 3'h1;
    end
  end
endmodule // tcs_far_end

// ---- tb_top.sv ----
// Self-checking bench for the timer clock select block.
// Assumes the far-end model drives the pins and external clock.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import tcs_pkg::*;
  localparam int W = 480;
  logic          clk = 1'b0;
  logic          rst_b = 1'b0;
  logic [7:0]    sfr_addr = 8'h00;
  logic          sfr_wr = 1'b0;
  logic          sfr_rd = 1'b0;
  logic [7:0]    sfr_wdata = 8'h00;
  logic [7:0]    sfr_rdata;
  logic          ev0, ev1, ext, done;
  logic          go = 1'b0;
  logic [3:0]    hp = 4'h2;
  logic [7:0]    num = 8'h00;
  tcs_t01_mode_t m0 = TCS_MODE_13;
  tcs_t01_mode_t m1 = TCS_MODE_13;
  logic          cm0 = 1'b0;
  logic          cm1 = 1'b0;
  logic [3:0]    split = 4'h0;
  logic [3:0]    alt = 4'h0;
  logic [10:0]   tk;
  logic          cnt_on = 1'b0;
  logic [31:0]   seed = 32'h0000_0024;
  int            cnt [11];
  int            mismatches = 0;
  int            comparisons = 0;
  int            cyc = 0;

  tcs_top u_dut (
    .clk(clk), .rst_b(rst_b), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .event_input_zero(ev0), .event_input_one(ev1), .ext_osc_clk(ext),
    .timer_zero_mode(m0), .timer_one_mode(m1),
    .timer_zero_counter_mode(cm0), .timer_one_counter_mode(cm1),
    .timer_two_split(split[0]), .timer_three_split(split[1]),
    .timer_four_split(split[2]), .timer_five_split(split[3]),
    .timer_two_alt_clock_bit(alt[0]), .timer_three_alt_clock_bit(alt[1]),
    .timer_four_alt_clock_bit(alt[2]), .timer_five_alt_clock_bit(alt[3]),
    .timer_zero_tick(tk[0]), .timer_zero_high_tick(tk[1]),
    .timer_one_tick(tk[2]), .timer_two_low_tick(tk[3]),
    .timer_two_high_tick(tk[4]), .timer_three_low_tick(tk[5]),
    .timer_three_high_tick(tk[6]), .timer_four_low_tick(tk[7]),
    .timer_four_high_tick(tk[8]), .timer_five_low_tick(tk[9]),
    .timer_five_high_tick(tk[10]));
  tcs_far_end u_far (.clk(clk), .rst_b(rst_b), .go(go), .half(hp),
    .count(num), .event_input_zero(ev0), .event_input_one(ev1),
    .ext_osc_clk(ext), .done(done));

  always #20 clk = ~clk;
  always @(posedge clk) begin
    if (cnt_on) begin
      foreach (cnt[i]) cnt[i] += int'(tk[i]);
    end
  end
  // Ceiling well above the roughly 4300 cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      print_verdict();
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int presc(input logic [1:0] ps);
    return ps == 2'b00 ? W / 12 : ps == 2'b01 ? W / 4 : W / 48;
  endfunction
  function automatic int rate(input logic sys, input logic alt_b);
    return sys ? W : (alt_b ? W / 48 : W / 12);
  endfunction
  task automatic chk(input string what, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
    @(negedge clk);
    d = sfr_rdata;
  endtask
  task automatic window();
    repeat (8) @(posedge clk);
    foreach (cnt[i]) cnt[i] = 0;
    cnt_on <= 1'b1;
    repeat (W) @(posedge clk);
    cnt_on <= 1'b0;
  endtask
  task automatic burst(input logic [3:0] h, input logic [7:0] n);
    int k;
    repeat (4) @(posedge clk);
    foreach (cnt[i]) cnt[i] = 0;
    cnt_on <= 1'b1;
    hp <= h;
    num <= n;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    k = 0;
    while (done !== 1'b1 && k < 1000) begin
      @(posedge clk);
      k++;
    end
    repeat (8) @(posedge clk);
    cnt_on <= 1'b0;
    @(posedge clk);
    chk("t0_events", cnt[0], n);
    chk("t1_events", cnt[2], n);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    logic [7:0]  d, ck, ck1;
    logic [11:0] sel;
    logic [31:0] r;
    int          e;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    rd(8'h8e, d);
    chk("timer_clock_control_rst", d, 8'h00);
    wr(8'hf4, 8'hff);
    rd(8'hf4, d);
    chk("timer_clock_control_ext_wr", d, 8'h0f);
    wr(8'h33, 8'hff);
    rd(8'h33, d);
    chk("unmapped", d, 8'h00);
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      ck = i == 0 ? 8'h01 : i == 1 ? 8'hfc : r[23:16];
      ck1 = i == 1 ? 8'hff : r[31:24];
      sel = {ck1[3:0], ck[7:4]};
      wr(8'h8e, ck);
      wr(8'hf4, ck1);
      m0 <= tcs_t01_mode_t'(r[1:0]);
      m1 <= tcs_t01_mode_t'(r[3:2]);
      split <= r[7:4];
      alt <= r[11:8];
      window();
      rd(8'h8e, d);
      chk("timer_clock_control", d, ck);
      rd(8'hf4, d);
      chk("timer_clock_control_ext", d, {4'h0, ck1[3:0]});
      chk("t0", cnt[0], ck[2] ? W : presc(ck[1:0]));
      // Split mode lets the high byte run on Timer 0's own clock choice
      e = r[1:0] == 2'b11 ? (ck[2] ? W : presc(ck[1:0])) : 0;
      chk("t0_high", cnt[1], e);
      e = r[3:2] == 2'b11 ? 0 : ck[3] ? W : presc(ck[1:0]);
      chk("t1", cnt[2], e);
      for (int t = 0; t < 4; t++) begin
        e = rate(sel[2*t], r[8+t]);
        chk("t_low", cnt[3+2*t], e);
        e = r[4+t] ? rate(sel[2*t+1], r[8+t]) : e;
        chk("t_high", cnt[4+2*t], e);
      end
    end
    wr(8'h8e, 8'h0c);
    cm0 <= 1'b1;
    cm1 <= 1'b1;
    m0 <= TCS_MODE_16;
    m1 <= TCS_MODE_16;
    burst(4'h2, 8'h10);
    r = rnd();
    burst(4'h3 + 4'(r % 4), 8'(r[15:8] % 20 + 1));
    print_verdict();
  end
endmodule // tb_top
